// >>> rtl/hall_commutator_deadtime.sv
// brushless commutation decoder with direction dead-time blanking
// assumes Hall sensor pins asynchronous to hclk and one AHB-Lite master
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - blanking works only while blank enable set
// - direction change blanks outputs two oscillator periods
// - three-stage shift register fed by direction
// - only stages run on oscillator tick
// - outputs enabled when all stages agree
// - first stage change disables gates until last
// - blanking starts within one oscillator period
// - select bit one picks 30-degree decoding
// - reversed 30-degree sequence uses 30-degree decoding
// - rotated 60-degree sequences use 60-degree decoding
// - shifted 30-degree sequence uses 30-degree decoding
// - 60-degree code table to sink/source pairs
// - 30-degree code table to same pairs
// - direction low swaps sink and source
// - inhibit forces all six outputs off
module hall_commutator_deadtime (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rotor_sensor_a,
	input wire logic rotor_sensor_b,
	input wire logic rotor_sensor_c,
	output hall_commutator_pkg::drive_t drive
);
	import hall_commutator_pkg::*;

	state_t cur;
	state_t next_state;

	// range index 0..5 for a valid code, 7 for a code outside the table
	function automatic logic [2:0] decode_range(input logic [2:0] code, input logic sel30);
		logic [2:0] r;
		r = 3'h7;
		if (sel30) begin
			unique case (code)
				3'h0: r = 3'h0;
				3'h1: r = 3'h1;
				3'h3: r = 3'h2;
				3'h7: r = 3'h3;
				3'h6: r = 3'h4;
				3'h4: r = 3'h5;
				default: r = 3'h7;
			endcase
		end else begin
			unique case (code)
				3'h5: r = 3'h0;
				3'h4: r = 3'h1;
				3'h6: r = 3'h2;
				3'h2: r = 3'h3;
				3'h3: r = 3'h4;
				3'h1: r = 3'h5;
				default: r = 3'h7;
			endcase
		end
		return r;
	endfunction : decode_range

	function automatic drive_t range_drive(input logic [2:0] r);
		drive_t d;
		d = '0;
		unique case (r)
			3'h0: d = '{sink: 3'h1, source: 3'h2};
			3'h1: d = '{sink: 3'h1, source: 3'h4};
			3'h2: d = '{sink: 3'h2, source: 3'h4};
			3'h3: d = '{sink: 3'h2, source: 3'h1};
			3'h4: d = '{sink: 3'h4, source: 3'h1};
			3'h5: d = '{sink: 3'h4, source: 3'h2};
			default: d = '0;
		endcase
		return d;
	endfunction : range_drive

	logic gate_all_high;
	logic gate_all_low;
	logic outputs_enabled;
	logic osc_tick;
	drive_t decoded;
	logic [2:0] range_idx;
	logic addr_phase;
	logic [11:0] addr_low;
	logic [31:0] read_value;

	always_comb begin
		next_state = cur;

		// sensor pins pass two flip-flops before decoding
		next_state.sens_meta = {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};
		next_state.sens_sync = cur.sens_meta;

		// dead-time oscillator: one tick per programmed period
		osc_tick = (cur.osc_count == 16'h0000);
		if (osc_tick) begin
			next_state.osc_count = (cur.osc_period == 16'h0000) ? 16'h0000 : cur.osc_period - 16'h0001;
		end else begin
			next_state.osc_count = cur.osc_count - 16'h0001;
		end

		// stages sample direction only on the tick; the sink/source swap reads it every cycle
		if (osc_tick) begin
			next_state.stages = {cur.stages[1:0], cur.ctrl[CTRL_DIRECTION_BIT]};
		end

		gate_all_high = &cur.stages;
		gate_all_low = ~|cur.stages;
		// any stage disagreeing closes both gates
		outputs_enabled = cur.ctrl[CTRL_BLANK_EN_BIT] ? (gate_all_high | gate_all_low) : 1'b1;

		// sensor order a,b,c maps to code bits 2,1,0
		range_idx = decode_range(cur.sens_sync, cur.ctrl[CTRL_SEL30_BIT]);
		decoded = range_drive(range_idx);
		if (!cur.ctrl[CTRL_DIRECTION_BIT]) begin
			decoded = '{sink: decoded.source, source: decoded.sink};
		end
		if (cur.ctrl[CTRL_INHIBIT_BIT] || !outputs_enabled) begin
			decoded = '0;
		end
		next_state.drive = decoded;

		// ahb-lite slave, zero wait states, always okay
		addr_phase = hsel && htrans[1] && hready;
		addr_low = {haddr[11:2], 2'b00};
		read_value = 32'h0000_0000;
		unique case (addr_low)
			CTRL_OFFSET: read_value = {28'h000_0000, cur.ctrl};
			OSC_OFFSET: read_value = {16'h0000, cur.osc_period};
			STATUS_OFFSET: begin
				read_value[STATUS_SENSOR_LSB +: 3] = cur.sens_sync;
				read_value[STATUS_STAGE_LSB +: 3] = cur.stages;
				read_value[STATUS_GATE_LSB] = gate_all_high;
				read_value[STATUS_GATE_LSB + 1] = gate_all_low;
				read_value[STATUS_DRIVE_LSB +: 6] = cur.drive;
			end
			default: read_value = 32'h0000_0000;
		endcase

		if (cur.wr_pending) begin
			unique case (cur.wr_addr)
				CTRL_OFFSET: next_state.ctrl = hwdata[3:0];
				OSC_OFFSET: next_state.osc_period = hwdata[15:0];
				default: next_state.ctrl = next_state.ctrl;
			endcase
		end

		next_state.wr_pending = addr_phase && hwrite;
		next_state.wr_addr = addr_low;
		next_state.rdata = (addr_phase && !hwrite) ? read_value : 32'h0000_0000;
		next_state.readyout = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '{sens_meta: 3'h0, sens_sync: 3'h0, ctrl: CTRL_RESET, osc_period: OSC_RESET,
				osc_count: OSC_RESET, stages: STAGES_RESET, wr_pending: 1'b0, wr_addr: 12'h000,
				rdata: 32'h0000_0000, readyout: 1'b1, drive: '0};
		end else begin
			cur <= next_state;
		end
	end

	assign hrdata = cur.rdata;
	assign hreadyout = cur.readyout;
	assign hresp = 1'b0;
	assign drive = cur.drive;

	initial begin
		assert (OSC_PERIOD_CYCLES >= 1 && OSC_PERIOD_CYCLES < 65536)
		else $error("oscillator period does not fit its register");
	end
endmodule : hall_commutator_deadtime

// >>> rtl/hall_commutator_pkg.sv
// constants, register map and carrier types of the hall commutator
// assumes a 100 MHz hclk and a single AHB-Lite slave port
package hall_commutator_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// dead-time clock period, two of them form the blanking window
	localparam int OSC_PERIOD_NS = 2400;
	localparam int OSC_PERIOD_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_PERIODS = 2;

	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] OSC_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;

	localparam int CTRL_DIRECTION_BIT = 0;
	localparam int CTRL_INHIBIT_BIT = 1;
	localparam int CTRL_BLANK_EN_BIT = 2;
	localparam int CTRL_SEL30_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h6;
	localparam logic [15:0] OSC_RESET = 16'(OSC_PERIOD_CYCLES);
	// stages disagree after reset so the outputs start blanked
	localparam logic [2:0] STAGES_RESET = 3'h2;

	localparam int STATUS_SENSOR_LSB = 0;
	localparam int STATUS_STAGE_LSB = 4;
	localparam int STATUS_GATE_LSB = 8;
	localparam int STATUS_DRIVE_LSB = 12;

	typedef struct packed {
		logic [2:0] sink;
		logic [2:0] source;
	} drive_t;

	typedef struct packed {
		logic [2:0] sens_meta;
		logic [2:0] sens_sync;
		logic [3:0] ctrl;
		logic [15:0] osc_period;
		logic [15:0] osc_count;
		logic [2:0] stages;
		logic wr_pending;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic readyout;
		drive_t drive;
	} state_t;
endpackage : hall_commutator_pkg

// >>> verif/hall_sensor_model.sv
// hall sensor model, drives the three rotor pins from a position code
// assumes pos bit2 goes to sensor a; quad ties sensor c to sensor b
`timescale 1ns/1ps
module hall_sensor_model (
	input wire logic [2:0] pos,
	input wire logic quad,
	output logic rotor_sensor_a,
	output logic rotor_sensor_b,
	output logic rotor_sensor_c
);
	assign rotor_sensor_a = pos[2];
	assign rotor_sensor_b = pos[1];
	assign rotor_sensor_c = quad ? pos[1] : pos[0];
endmodule : hall_sensor_model

// >>> verif/hall_commutator_sva.sv
// port assertions of the hall commutator
// assumes hready is tied to hreadyout
`timescale 1ns/1ps
module hall_commutator_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire hall_commutator_pkg::drive_t drive
);
	import hall_commutator_pkg::*;
	logic rd;
	logic wrote;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd <= 1'b0;
			wrote <= 1'b0;
		end else begin
			rd <= hsel & htrans[1] & hready & !hwrite;
			wrote <= wrote | (hsel & htrans[1] & hready & hwrite);
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_ready; hreadyout ##1 hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	property p_rdzero; !rd |-> hrdata == 32'h0; endproperty
	a_rdzero: assert property (p_rdzero) else $error("hrdata outside data phase");
	property p_sink; $onehot0(drive.sink); endproperty
	a_sink: assert property (p_sink) else $error("more than one sink on");
	property p_source; $onehot0(drive.source); endproperty
	a_source: assert property (p_source) else $error("more than one source on");
	property p_pair; (drive.sink != 3'h0) == (drive.source != 3'h0); endproperty
	a_pair: assert property (p_pair) else $error("half a pair on");
	property p_apart; (drive.sink & drive.source) == 3'h0; endproperty
	a_apart: assert property (p_apart) else $error("sink and source on one phase");
	property p_idle; !wrote |-> drive == 6'h0; endproperty
	a_idle: assert property (p_idle) else $error("drive on before setup");
endmodule : hall_commutator_checker
bind hall_commutator_deadtime hall_commutator_checker chk_u (.*);

// >>> verif/hall_commutator_deadtime_test.sv
// self-checking bench of the hall commutator
// assumes the sensor model and the bound checker are compiled alongside
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("unexpected %0t value %h", $time, g); end end
module hall_commutator_deadtime_test;
	import hall_commutator_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] pos = 3'h0;
	logic quad = 1'b0;
	logic hready, hreadyout, hresp, rotor_sensor_a, rotor_sensor_b, rotor_sensor_c;
	logic [31:0] hrdata, q;
	drive_t drive;
	int failures = 0, n_checks = 0, cyc = 0, w, z;
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	hall_commutator_deadtime dut_u (.*);
	hall_sensor_model model_u (.*);
	function automatic drive_t want(input logic s30, input logic [2:0] code, input logic dir);
		logic [17:0] t;
		drive_t d;
		t = s30 ? {3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4} : {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
		d = '0;
		for (int i = 0; i < 6; i++) if (t[17-3*i -: 3] == code) d = '{3'h1 << (i/2), 3'h1 << ((i/2+1+i%2)%3)};
		if (!dir) d = '{d.source, d.sink};
		return d;
	endfunction : want
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : xfer
	task conclude();
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		`CHK(drive, 6'h0)
		xfer(1'b1, OSC_OFFSET, 32'h4, q);
		for (int k = 0; k < 32; k++) begin
			pos <= k[2:0];
			xfer(1'b1, CTRL_OFFSET, {28'h0, k[4], 2'h0, k[3]}, q);
			repeat (4) @(posedge hclk);
			`CHK(drive, want(k[4], k[2:0], k[3]))
		end
		quad <= 1'b1;
		pos <= 3'h1;
		xfer(1'b1, CTRL_OFFSET, 32'h9, q);
		repeat (4) @(posedge hclk);
		`CHK(drive, want(1'b1, 3'h0, 1'b1))
		quad <= 1'b0;
		pos <= 3'h5;
		xfer(1'b1, CTRL_OFFSET, 32'h3, q);
		repeat (4) @(posedge hclk);
		`CHK(drive, 6'h0)
		xfer(1'b0, CTRL_OFFSET, 32'h0, q);
		`CHK(q[3:0], 4'h3)
		xfer(1'b0, 12'hFF0, 32'h0, q);
		`CHK(q, 32'h0)
		xfer(1'b1, CTRL_OFFSET, 32'h5, q);
		repeat (16) @(posedge hclk);
		`CHK(drive, want(1'b0, 3'h5, 1'b1))
		xfer(1'b1, CTRL_OFFSET, 32'h4, q);
		w = 0;
		while (drive !== 6'h0 && w < 8) begin
			@(posedge hclk);
			w++;
		end
		`CHK(w <= 6, 1'b1)
		z = 0;
		while (drive === 6'h0 && z < 20) begin
			@(posedge hclk);
			z++;
		end
		`CHK(z, 8)
		`CHK(drive, want(1'b0, 3'h5, 1'b0))
		xfer(1'b0, STATUS_OFFSET, 32'h0, q);
		`CHK(q, 32'h0001_1205)
		conclude();
	end
endmodule : hall_commutator_deadtime_test
